/* File: tb/rpsf_far_model.sv */
`timescale 1ns/1ps

// far side of the receive ports: event pulses, live levels and parity counts
module rpsf_far_model (
    input wire logic clk_in,
    output logic [1:0] crc_out,
    output logic [1:0] order_out,
    output logic [1:0] unsteady_out,
    output logic [1:0] width_out,
    output logic [1:0] coding_out,
    output logic [1:0] overflow_out,
    output logic [1:0] total_out,
    output logic [1:0] locked_out,
    output logic [1:0] pass_out,
    output logic [1:0] camera_out,
    output logic [1:0] settled_out,
    output logic [1:0] clk_missing_out,
    output logic [31:0] par_count_out,
    output logic [31:0] par_limit_out
);
    // coding pulses model faults counted with a fault limit above one, so lock loss never hides them
    logic [6:0][1:0] ev = '0;
    logic [4:0][1:0] lv = '0;
    initial begin
        par_count_out = 32'h0000_0000;
        par_limit_out = 32'h0000_0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // fan out of event and level vectors
    assign crc_out = ev[0];
    assign order_out = ev[1];
    assign unsteady_out = ev[2];
    assign width_out = ev[3];
    assign coding_out = ev[4];
    assign overflow_out = ev[5];
    assign total_out = ev[6];
    assign locked_out = lv[0];
    assign pass_out = lv[1];
    assign camera_out = lv[2];
    assign settled_out = lv[3];
    assign clk_missing_out = lv[4];
    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle event pulse, launched just after a rising edge
    task automatic pulse(input int k, input int p);
        @(posedge clk_in);
        ev[k][p] <= 1'b1;
        @(posedge clk_in);
        ev[k][p] <= 1'b0;
    endtask
    // live level change
    task automatic set_level(input int k, input int p, input logic v);
        @(posedge clk_in);
        lv[k][p] <= v;
    endtask
    // parity count and limit of one port
    task automatic set_parity(input int p, input logic [15:0] c, input logic [15:0] l);
        @(posedge clk_in);
        par_count_out[p*16+:16] <= c;
        par_limit_out[p*16+:16] <= l;
    endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "rpsf_consts.svh"

module testbench;
    import rpsf_pkg::*;
    logic ref_clk_in, rst_n_in, reg_rd_in, read_port_sel_in, rd_valid_out;
    logic [7:0] reg_addr_in;
    logic [1:0] crc, order, unst, width, coding, ovf, total, lock, pass, cam, settled, clkm;
    logic [31:0] pcnt, plim;
    rpsf_byte_t rd_data_out;
    int fails, n_compared;
    logic [7:0] ev_addr [7] = '{`RPSF_ADDR_FIRST, `RPSF_ADDR_FIRST, `RPSF_ADDR_SECOND,
        `RPSF_ADDR_SECOND, `RPSF_ADDR_SECOND, `RPSF_ADDR_SECOND, `RPSF_ADDR_SECOND};
    int ev_bit [7] = '{`RPSF_F1_CRC, `RPSF_F1_ORDER, `RPSF_F2_UNSTEADY, `RPSF_F2_WIDTH_CHG,
        `RPSF_F2_CODING, `RPSF_F2_OVERFLOW, `RPSF_F2_TOTAL_CHG};
    logic [7:0] lv_addr [5] = '{`RPSF_ADDR_FIRST, `RPSF_ADDR_FIRST, `RPSF_ADDR_SECOND,
        `RPSF_ADDR_SECOND, `RPSF_ADDR_SECOND};
    int lv_bit [5] = '{`RPSF_F1_LOCKED, `RPSF_F1_PASS, `RPSF_F2_CAMERA,
        `RPSF_F2_RATE_SETTLED, `RPSF_F2_CLK_MISSING};

    rpsf_top u_rpsf_top (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in),
        .reg_rd_in(reg_rd_in),
        .read_port_sel_in(read_port_sel_in),
        .ctrl_channel_crc_flag_in(crc),
        .ctrl_channel_order_flag_in(order),
        .receiver_locked_in(lock),
        .port_pass_in(pass),
        .parity_fault_counters_in(pcnt),
        .parity_limit_setting_in(plim),
        .row_width_unsteady_in(unst),
        .row_width_changed_in(width),
        .link_coding_fault_in(coding),
        .buffer_overflow_in(ovf),
        .camera_rx_error_in(cam),
        .rate_measure_settled_in(settled),
        .link_clock_missing_in(clkm),
        .row_total_changed_in(total),
        .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out)
    );
    rpsf_far_model u_rpsf_far_model (
        .clk_in(ref_clk_in),
        .crc_out(crc),
        .order_out(order),
        .unsteady_out(unst),
        .width_out(width),
        .coding_out(coding),
        .overflow_out(ovf),
        .total_out(total),
        .locked_out(lock),
        .pass_out(pass),
        .camera_out(cam),
        .settled_out(settled),
        .clk_missing_out(clkm),
        .par_count_out(pcnt),
        .par_limit_out(plim)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #100us;
        fails++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input rpsf_byte_t got, input rpsf_byte_t exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one read strobe; the port number field is added to every first-register byte
    task automatic rd(input logic [7:0] a, input logic p, input rpsf_byte_t m, input rpsf_byte_t x);
        rpsf_byte_t e;
        e = x;
        if (a == `RPSF_ADDR_FIRST) begin
            e = e | {1'b0, p, 6'h00};
        end
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        read_port_sel_in <= p;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        check({7'h00, rd_valid_out}, 8'h01);
        check(rd_data_out & m, e & m);
    endtask
    task automatic conclude();
        $display("fails %0d n_compared %0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n_in = 1'b0;
        reg_rd_in = 1'b0;
        reg_addr_in = 8'h00;
        read_port_sel_in = 1'b0;
        fails = 0;
        n_compared = 0;
        repeat (4) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        // quiet state of both ports, plus an unmapped offset
        for (int p = 0; p < 2; p++) begin
            rd(`RPSF_ADDR_FIRST, p[0], 8'hff, 8'h00);
            rd(`RPSF_ADDR_SECOND, p[0], 8'hff, 8'h00);
            rd(8'h4f, p[0], 8'hff, 8'h00);
        end
        // every sticky event on each port: other port untouched, set, then cleared by the read
        for (int k = 0; k < 7; k++) begin
            for (int p = 0; p < 2; p++) begin
                u_rpsf_far_model.pulse(k, p);
                rd(ev_addr[k], !p[0], 8'hff, 8'h00);
                rd(ev_addr[k], p[0], 8'hff, 8'h01 << ev_bit[k]);
                rd(ev_addr[k], p[0], 8'hff, 8'h00);
            end
        end
        // lock rises then falls; each change leaves a sticky mark
        u_rpsf_far_model.set_level(0, 1, 1'b1);
        rd(`RPSF_ADDR_FIRST, 1'b1, 8'hff, 8'h11);
        rd(`RPSF_ADDR_FIRST, 1'b1, 8'hff, 8'h01);
        rd(`RPSF_ADDR_FIRST, 1'b0, 8'hff, 8'h00);
        u_rpsf_far_model.set_level(0, 1, 1'b0);
        rd(`RPSF_ADDR_FIRST, 1'b1, 8'hff, 8'h10);
        rd(`RPSF_ADDR_FIRST, 1'b1, 8'hff, 8'h00);
        // live levels survive reads and follow their source
        for (int k = 1; k < 5; k++) begin
            u_rpsf_far_model.set_level(k, 0, 1'b1);
            rd(lv_addr[k], 1'b0, 8'hff, 8'h01 << lv_bit[k]);
            rd(lv_addr[k], 1'b0, 8'hff, 8'h01 << lv_bit[k]);
            rd(lv_addr[k], 1'b1, 8'hff, 8'h00);
            u_rpsf_far_model.set_level(k, 0, 1'b0);
            rd(lv_addr[k], 1'b0, 8'hff, 8'h00);
        end
        // parity flag: equal to the limit is not over it, clearing the count drops it
        u_rpsf_far_model.set_parity(1, 16'h0005, 16'h0005);
        rd(`RPSF_ADDR_FIRST, 1'b1, 8'hff, 8'h00);
        u_rpsf_far_model.set_parity(1, 16'h0006, 16'h0005);
        rd(`RPSF_ADDR_FIRST, 1'b1, 8'hff, 8'h04);
        rd(`RPSF_ADDR_FIRST, 1'b1, 8'hff, 8'h04);
        rd(`RPSF_ADDR_FIRST, 1'b0, 8'hff, 8'h00);
        u_rpsf_far_model.set_parity(1, 16'h0000, 16'h0005);
        rd(`RPSF_ADDR_FIRST, 1'b1, 8'hff, 8'h00);
        // event landing on the clearing read must not be lost
        fork
            u_rpsf_far_model.pulse(4, 0);
            rd(`RPSF_ADDR_SECOND, 1'b0, 8'hff, 8'h00);
        join
        rd(`RPSF_ADDR_SECOND, 1'b0, 8'hff, 8'h20);
        // crc event one edge before the read strobe is already visible to it
        fork
            u_rpsf_far_model.pulse(0, 0);
            begin
                @(posedge ref_clk_in);
                rd(`RPSF_ADDR_FIRST, 1'b0, 8'hff, 8'h20);
            end
        join
        rd(`RPSF_ADDR_FIRST, 1'b0, 8'hff, 8'h00);
        // crc event on the clearing read of port 1 survives that read
        fork
            u_rpsf_far_model.pulse(0, 1);
            rd(`RPSF_ADDR_FIRST, 1'b1, 8'hff, 8'h00);
        join
        rd(`RPSF_ADDR_FIRST, 1'b1, 8'hff, 8'h20);
        conclude();
    end
endmodule

/* File: verilog/rpsf_consts.svh */
`ifndef RPSF_CONSTS_SVH
`define RPSF_CONSTS_SVH

// register offsets on the paged register map
`define RPSF_ADDR_FIRST 8'h4d
`define RPSF_ADDR_SECOND 8'h4e
`define RPSF_UNMAPPED_DATA 8'h00
`define RPSF_FLAGS_RESET 8'h00

// first status register field positions
`define RPSF_F1_PORT_NUM 6
`define RPSF_F1_CRC 5
`define RPSF_F1_LOCK_CHG 4
`define RPSF_F1_ORDER 3
`define RPSF_F1_PARITY 2
`define RPSF_F1_PASS 1
`define RPSF_F1_LOCKED 0

// second status register field positions
`define RPSF_F2_UNSTEADY 7
`define RPSF_F2_WIDTH_CHG 6
`define RPSF_F2_CODING 5
`define RPSF_F2_OVERFLOW 4
`define RPSF_F2_CAMERA 3
`define RPSF_F2_RATE_SETTLED 2
`define RPSF_F2_CLK_MISSING 1
`define RPSF_F2_TOTAL_CHG 0

`endif

/* File: verilog/rpsf_pkg.sv */
package rpsf_pkg;
    typedef logic [7:0] rpsf_byte_t;
    // which status register a read addresses
    typedef enum logic [1:0] {
        RPSF_SEL_NONE = 2'b00,
        RPSF_SEL_FIRST = 2'b01,
        RPSF_SEL_SECOND = 2'b10
    } rpsf_reg_sel_t;
endpackage

/* File: verilog/rpsf_port_flags.sv */
`timescale 1ns/1ps
`include "rpsf_consts.svh"

module rpsf_port_flags (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic crc_evt_in,
    input wire logic order_evt_in,
    input wire logic unsteady_evt_in,
    input wire logic width_chg_evt_in,
    input wire logic coding_evt_in,
    input wire logic overflow_evt_in,
    input wire logic total_chg_evt_in,
    input wire logic locked_in,
    input wire logic clr_first_in,
    input wire logic clr_second_in,
    output rpsf_pkg::rpsf_byte_t first_flags_out,
    output rpsf_pkg::rpsf_byte_t second_flags_out
);
    import rpsf_pkg::*;

    rpsf_byte_t first_q;
    rpsf_byte_t second_q;
    rpsf_byte_t first_set;
    rpsf_byte_t second_set;
    logic lock_prev_q;
    logic lock_change;

    ////////////////////////////////////////////////////////////////////////
    // lock change is seen against the last sampled lock level
    assign lock_change = locked_in ^ lock_prev_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lock_prev_q <= 1'b0;
        end else begin
            lock_prev_q <= locked_in;
        end
    end

    // event vectors laid out at their register bit positions
    always_comb begin
        first_set = '0;
        first_set[`RPSF_F1_CRC] = crc_evt_in;
        first_set[`RPSF_F1_LOCK_CHG] = lock_change;
        first_set[`RPSF_F1_ORDER] = order_evt_in;
        second_set = '0;
        second_set[`RPSF_F2_UNSTEADY] = unsteady_evt_in;
        second_set[`RPSF_F2_WIDTH_CHG] = width_chg_evt_in;
        second_set[`RPSF_F2_CODING] = coding_evt_in;
        second_set[`RPSF_F2_OVERFLOW] = overflow_evt_in;
        second_set[`RPSF_F2_TOTAL_CHG] = total_chg_evt_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky flags: the set term is or-ed after the clear so a coinciding
    // event survives the clearing read
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            first_q <= `RPSF_FLAGS_RESET;
        end else begin
            first_q <= (first_q & ~{8{clr_first_in}}) | first_set;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            second_q <= `RPSF_FLAGS_RESET;
        end else begin
            second_q <= (second_q & ~{8{clr_second_in}}) | second_set;
        end
    end

    assign first_flags_out = first_q;
    assign second_flags_out = second_q;

    ////////////////////////////////////////////////////////////////////////
    property p_crc_set_wins;
        @(posedge clk_in) disable iff (!rst_n_in)
        (crc_evt_in && clr_first_in) |=> first_q[`RPSF_F1_CRC];
    endproperty
    a_crc_set_wins: assert property (p_crc_set_wins) else $error("crc flag lost on clear");

    property p_lock_change;
        @(posedge clk_in) disable iff (!rst_n_in)
        $changed(locked_in) |=> first_q[`RPSF_F1_LOCK_CHG];
    endproperty
    a_lock_change: assert property (p_lock_change) else $error("lock change not flagged");

    property p_width_cleared;
        @(posedge clk_in) disable iff (!rst_n_in)
        (clr_second_in && !width_chg_evt_in) |=> !second_q[`RPSF_F2_WIDTH_CHG];
    endproperty
    a_width_cleared: assert property (p_width_cleared) else $error("width flag not cleared");

    property p_total_held;
        @(posedge clk_in) disable iff (!rst_n_in)
        (total_chg_evt_in ##1 !clr_second_in) |=> second_q[`RPSF_F2_TOTAL_CHG];
    endproperty
    a_total_held: assert property (p_total_held) else $error("row total flag not held");
endmodule

/* File: verilog/rpsf_top.sv */
`timescale 1ns/1ps
`include "rpsf_consts.svh"

// Operation
// - first register bit 6 returns the currently selected read port number.
// - control channel crc error sets first register bit 5, cleared on read.
// - lock state change since last read sets bit 4, cleared on read.
// - control channel sequence error sets first register bit 3, cleared on read.
// - bit 2 high while parity count exceeds limit; drops when counters cleared.
// - bit 1 shows the live pass indication from the pass criteria control.
// - bit 0 shows the live receiver lock state.
// - second register bit 7 set on differing row widths, held until read.
// - row width change sets second register bit 6, cleared on read.
// - link coding fault sets second register bit 5, cleared on read.
// - packet buffer overflow sets second register bit 4, cleared on read.
// - bit 3 is a read-only camera receive error summary.
// - bit 1 is read-only, high when no link input clock is seen.
// - row total change sets second register bit 0, cleared on read.
// - registers shown are those of the port picked by the read select.
module rpsf_top #(
    parameter int NPORTS = 2,
    parameter int CNT_W = 16
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic read_port_sel_in,
    input wire logic [NPORTS-1:0] ctrl_channel_crc_flag_in,
    input wire logic [NPORTS-1:0] ctrl_channel_order_flag_in,
    input wire logic [NPORTS-1:0] receiver_locked_in,
    input wire logic [NPORTS-1:0] port_pass_in,
    input wire logic [NPORTS*CNT_W-1:0] parity_fault_counters_in,
    input wire logic [NPORTS*CNT_W-1:0] parity_limit_setting_in,
    input wire logic [NPORTS-1:0] row_width_unsteady_in,
    input wire logic [NPORTS-1:0] row_width_changed_in,
    input wire logic [NPORTS-1:0] link_coding_fault_in,
    input wire logic [NPORTS-1:0] buffer_overflow_in,
    input wire logic [NPORTS-1:0] camera_rx_error_in,
    input wire logic [NPORTS-1:0] rate_measure_settled_in,
    input wire logic [NPORTS-1:0] link_clock_missing_in,
    input wire logic [NPORTS-1:0] row_total_changed_in,
    output rpsf_pkg::rpsf_byte_t rd_data_out,
    output logic rd_valid_out
);
    import rpsf_pkg::*;

    logic rst_meta_q;
    logic rst_sync_q;
    rpsf_reg_sel_t rd_sel;
    rpsf_byte_t first_flags [NPORTS];
    rpsf_byte_t second_flags [NPORTS];
    rpsf_byte_t first_live_q [NPORTS];
    rpsf_byte_t second_live_q [NPORTS];
    rpsf_byte_t rd_mux;
    rpsf_byte_t rd_data_q;
    logic rd_valid_q;
    logic [NPORTS-1:0] clr_first;
    logic [NPORTS-1:0] clr_second;
    logic lock_sel;
    logic clk_missing_sel;

    ////////////////////////////////////////////////////////////////////////
    // reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode; anything else is unmapped and reads as zero
    function automatic rpsf_reg_sel_t decode_addr(input logic [7:0] addr);
        rpsf_reg_sel_t sel;
        sel = RPSF_SEL_NONE;
        if (addr == `RPSF_ADDR_FIRST) begin
            sel = RPSF_SEL_FIRST;
        end else if (addr == `RPSF_ADDR_SECOND) begin
            sel = RPSF_SEL_SECOND;
        end
        return sel;
    endfunction

    assign rd_sel = decode_addr(reg_addr_in);

    ////////////////////////////////////////////////////////////////////////
    // per-port flag banks and live status sampling
    genvar gp;
    generate
        for (gp = 0; gp < NPORTS; gp = gp + 1) begin : g_port
            // a clearing read only touches the port that was selected
            assign clr_first[gp] = reg_rd_in && (rd_sel == RPSF_SEL_FIRST) &&
                (read_port_sel_in == gp[0]);
            assign clr_second[gp] = reg_rd_in && (rd_sel == RPSF_SEL_SECOND) &&
                (read_port_sel_in == gp[0]);

            rpsf_port_flags u_flags (
                .clk_in(ref_clk_in),
                .rst_n_in(rst_sync_q),
                .crc_evt_in(ctrl_channel_crc_flag_in[gp]),
                .order_evt_in(ctrl_channel_order_flag_in[gp]),
                .unsteady_evt_in(row_width_unsteady_in[gp]),
                .width_chg_evt_in(row_width_changed_in[gp]),
                .coding_evt_in(link_coding_fault_in[gp]),
                .overflow_evt_in(buffer_overflow_in[gp]),
                .total_chg_evt_in(row_total_changed_in[gp]),
                .locked_in(receiver_locked_in[gp]),
                .clr_first_in(clr_first[gp]),
                .clr_second_in(clr_second[gp]),
                .first_flags_out(first_flags[gp]),
                .second_flags_out(second_flags[gp])
            );

            // live levels are registered so reads see a steady byte; the
            // parity compare follows the counters, so clearing them drops it
            always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
                if (!rst_sync_q) begin
                    first_live_q[gp] <= `RPSF_FLAGS_RESET;
                    second_live_q[gp] <= `RPSF_FLAGS_RESET;
                end else begin
                    first_live_q[gp] <= '0;
                    first_live_q[gp][`RPSF_F1_PARITY] <=
                        parity_fault_counters_in[gp*CNT_W +: CNT_W] >
                        parity_limit_setting_in[gp*CNT_W +: CNT_W];
                    first_live_q[gp][`RPSF_F1_PASS] <= port_pass_in[gp];
                    first_live_q[gp][`RPSF_F1_LOCKED] <= receiver_locked_in[gp];
                    second_live_q[gp] <= '0;
                    second_live_q[gp][`RPSF_F2_CAMERA] <= camera_rx_error_in[gp];
                    second_live_q[gp][`RPSF_F2_RATE_SETTLED] <=
                        rate_measure_settled_in[gp];
                    second_live_q[gp][`RPSF_F2_CLK_MISSING] <=
                        link_clock_missing_in[gp];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read data of the selected port; flags are taken before the clear lands
    always_comb begin
        rd_mux = `RPSF_UNMAPPED_DATA;
        case (rd_sel)
            RPSF_SEL_FIRST: begin
                rd_mux = first_flags[read_port_sel_in] | first_live_q[read_port_sel_in];
                rd_mux[`RPSF_F1_PORT_NUM] = read_port_sel_in;
            end
            RPSF_SEL_SECOND: begin
                rd_mux = second_flags[read_port_sel_in] | second_live_q[read_port_sel_in];
            end
            default: begin
                rd_mux = `RPSF_UNMAPPED_DATA;
            end
        endcase
    end

    // answer one cycle after the read strobe
    always_ff @(posedge ref_clk_in or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rd_data_q <= `RPSF_FLAGS_RESET;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= reg_rd_in;
            if (reg_rd_in) begin
                rd_data_q <= rd_mux;
            end
        end
    end

    assign rd_data_out = rd_data_q;
    assign rd_valid_out = rd_valid_q;

    // live levels of the selected port, so checks can look one edge back at them
    assign lock_sel = receiver_locked_in[read_port_sel_in];
    assign clk_missing_sel = link_clock_missing_in[read_port_sel_in];

    ////////////////////////////////////////////////////////////////////////
    property p_port_num;
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        (reg_rd_in && reg_addr_in == `RPSF_ADDR_FIRST) |=>
            rd_valid_out && rd_data_out[`RPSF_F1_PORT_NUM] == $past(read_port_sel_in);
    endproperty
    a_port_num: assert property (p_port_num) else $error("port number wrong");

    property p_lock_live;
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        (reg_rd_in && reg_addr_in == `RPSF_ADDR_FIRST && $stable(receiver_locked_in)) |=>
            rd_data_out[`RPSF_F1_LOCKED] == $past(lock_sel);
    endproperty
    a_lock_live: assert property (p_lock_live) else $error("lock bit wrong");

    property p_reserved_zero;
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        (reg_rd_in && reg_addr_in == `RPSF_ADDR_FIRST) |=> !rd_data_out[7];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_crc_readback;
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        (ctrl_channel_crc_flag_in[0] && !read_port_sel_in ##1
            reg_rd_in && reg_addr_in == `RPSF_ADDR_FIRST && !read_port_sel_in) |=>
            rd_data_out[`RPSF_F1_CRC];
    endproperty
    a_crc_readback: assert property (p_crc_readback) else $error("crc flag not read");

    property p_unmapped;
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        (reg_rd_in && reg_addr_in != `RPSF_ADDR_FIRST && reg_addr_in != `RPSF_ADDR_SECOND)
            |=> rd_valid_out && rd_data_out == `RPSF_UNMAPPED_DATA;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_clock_missing;
        @(posedge ref_clk_in) disable iff (!rst_sync_q)
        (reg_rd_in && reg_addr_in == `RPSF_ADDR_SECOND && $stable(link_clock_missing_in))
            |=> rd_data_out[`RPSF_F2_CLK_MISSING] == $past(clk_missing_sel);
    endproperty
    a_clock_missing: assert property (p_clock_missing) else $error("clock missing bit wrong");
endmodule
